/* File: hdl/tmcap_pkg.sv */
// shared constants and carrier types for the 16-bit timer counter and capture block
package tmcap_pkg;
  // register indices on the byte-wide register port
  localparam logic [3:0] TMCAP_OFS_CTRL_A = 4'h0;
  localparam logic [3:0] TMCAP_OFS_CTRL_B = 4'h1;
  localparam logic [3:0] TMCAP_OFS_CNT_LO = 4'h2;
  localparam logic [3:0] TMCAP_OFS_CNT_HI = 4'h3;
  localparam logic [3:0] TMCAP_OFS_CAP_LO = 4'h4;
  localparam logic [3:0] TMCAP_OFS_CAP_HI = 4'h5;
  localparam logic [3:0] TMCAP_OFS_FLAGS = 4'h6;
  localparam logic [3:0] TMCAP_OFS_CMP_CS = 4'h7;
  // field positions
  localparam int TMCAP_A_WGM_LSB = 0;
  localparam int TMCAP_B_CS_LSB = 0;
  localparam int TMCAP_B_WGM_LSB = 3;
  localparam int TMCAP_B_EDGE_BIT = 6;
  localparam int TMCAP_B_NCANC_BIT = 7;
  localparam int TMCAP_F_OVF_BIT = 0;
  localparam int TMCAP_F_CAP_BIT = 1;
  localparam int TMCAP_C_SEL_BIT = 2;
  // reset values
  localparam logic [7:0] TMCAP_RST_BYTE = 8'h00;
  localparam logic [15:0] TMCAP_RST_WORD = 16'h0000;
  // fixed count limits
  localparam logic [15:0] TMCAP_MAX = 16'hFFFF;
  localparam logic [15:0] TMCAP_BOTTOM = 16'h0000;
  localparam logic [15:0] TMCAP_TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TMCAP_TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TMCAP_TOP_10BIT = 16'h03FF;
  // prescaler width and tap masks
  localparam int TMCAP_PRE_W = 10;
  localparam logic [9:0] TMCAP_PRE_DIV8 = 10'h007;
  localparam logic [9:0] TMCAP_PRE_DIV64 = 10'h03F;
  localparam logic [9:0] TMCAP_PRE_DIV256 = 10'h0FF;
  localparam logic [9:0] TMCAP_PRE_DIV1024 = 10'h3FF;
  // noise canceller sample depth
  localparam int TMCAP_NC_DEPTH = 4;

  // clock select codes
  typedef enum logic [2:0] {
    TMCAP_CS_STOP = 3'h0,
    TMCAP_CS_DIV1 = 3'h1,
    TMCAP_CS_DIV8 = 3'h2,
    TMCAP_CS_DIV64 = 3'h3,
    TMCAP_CS_DIV256 = 3'h4,
    TMCAP_CS_DIV1024 = 3'h5,
    TMCAP_CS_EXT_FALL = 3'h6,
    TMCAP_CS_EXT_RISE = 3'h7
  } tmcap_cs_e;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tmcap_bus_s;

  // counter status towards waveform logic
  typedef struct packed {
    logic [15:0] value;
    logic [3:0] mode;
    logic top;
    logic bottom;
    logic down;
  } tmcap_cnt_s;
endpackage

/* File: hdl/tmcap_timer16.sv */
// 16-bit up/down counter with shared high-byte latch and input capture unit
// What this block does
// RULE1 - one 8-bit high-byte latch serves every 16-bit register of the timer
// RULE2 - latch keeps its byte after a low-byte write, reusable for next register
// RULE3 - three-bit clock select field in control B picks internal or external clock
// RULE4 - counter steps by one up or down, or clears, on each timer clock
// RULE5 - TOP flags the sequence maximum, BOTTOM flags a zero counter
// RULE6 - upper-byte access hits the latch; low read loads it, low write drains it
// RULE7 - clock select zero stops counting, counter stays readable and writable
// RULE8 - software counter write beats a clear or count in the same cycle
// RULE9 - four-bit waveform mode split over control A and B picks the sequence
// RULE10 - overflow flag set where the mode says, and it requests an interrupt
// RULE11 - trigger from capture pin; comparator output only on instance with comparator
// RULE12 - matching edge of the trigger copies the whole counter into capture register
// RULE13 - capture flag set in the same cycle the capture register is loaded
// RULE14 - capture flag clears on interrupt service or on writing a one
// RULE15 - capture low byte read first loads latch; upper read returns latch
// RULE16 - capture register writable only in modes using it as TOP, upper first
// RULE17 - comparator select bit routes comparator; software clears flag after switching
// RULE18 - noise canceller output moves only after four equal samples, feeds edge detector
// RULE19 - enabled canceller adds four system clocks from input change to capture
// RULE20 - canceller enable in control B, runs on system clock, ignores prescaler
// RULE21 - canceller and edge detector idle only in modes using capture as TOP; only the edge detector is gated, the canceller keeps sampling
// RULE22 - pin driven by software captures too; each capture overwrites the register
// RULE23 - edge select bit chooses rising or falling trigger transitions
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module tmcap_timer16 #(
  parameter bit HAS_COMPARATOR = 1'b1
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire tmcap_pkg::tmcap_bus_s i_bus,
  output logic [7:0] o_rdata,
  input wire logic i_capture_input_pin,
  input wire logic i_comparator_output,
  input wire logic i_ext_clk_pin,
  input wire logic [15:0] i_compare_a_top,
  input wire logic i_overflow_irq_ack,
  input wire logic i_capture_irq_ack,
  output logic o_overflow_flag,
  output logic o_capture_flag,
  output tmcap_pkg::tmcap_cnt_s o_counter
);
  import tmcap_pkg::*;

  // whole block state
  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic cmp_sel;
    logic [7:0] temp;
    logic [15:0] cnt;
    logic down;
    logic [15:0] cap;
    logic ovf;
    logic capf;
    logic top;
    logic bottom;
    logic [TMCAP_PRE_W-1:0] pre;
    logic [1:0] ext_sync;
    logic ext_prev;
    logic [1:0] pin_sync;
    logic [1:0] cmp_sync;
    logic [TMCAP_NC_DEPTH-1:0] nc_sr;
    logic nc_hold;
    logic det_prev;
  } tmcap_state_s;

  tmcap_state_s st_r;
  tmcap_state_s st_nxt;

  logic [3:0] wgm;
  tmcap_cs_e cs;
  logic [15:0] top_val;
  logic dual_slope;
  logic fast_pwm;
  logic clear_at_top;
  logic cap_is_top;
  logic tick;
  logic ext_edge_rise;
  logic ext_edge_fall;
  logic trig_raw;
  logic nc_all_eq;
  logic nc_out;
  logic det_in;
  logic cap_event;
  logic wr_cnt_lo;
  logic wr_cap_lo;
  logic tov_set;

  // mode decode shared by counter and capture
  always_comb begin
    // waveform mode split over the two control bytes
    // RULE9 mode field join
    wgm = {st_r.ctrl_b[TMCAP_B_WGM_LSB +: 2], st_r.ctrl_a[TMCAP_A_WGM_LSB +: 2]};
    cs = tmcap_cs_e'(st_r.ctrl_b[TMCAP_B_CS_LSB +: 3]);
    dual_slope = 1'b0;
    fast_pwm = 1'b0;
    clear_at_top = 1'b0;
    cap_is_top = 1'b0;
    top_val = TMCAP_MAX;
    unique case (wgm)
      4'h1: begin
        top_val = TMCAP_TOP_8BIT;
        dual_slope = 1'b1;
      end
      4'h2: begin
        top_val = TMCAP_TOP_9BIT;
        dual_slope = 1'b1;
      end
      4'h3: begin
        top_val = TMCAP_TOP_10BIT;
        dual_slope = 1'b1;
      end
      4'h4: begin
        top_val = i_compare_a_top;
        clear_at_top = 1'b1;
      end
      4'h5: begin
        top_val = TMCAP_TOP_8BIT;
        fast_pwm = 1'b1;
      end
      4'h6: begin
        top_val = TMCAP_TOP_9BIT;
        fast_pwm = 1'b1;
      end
      4'h7: begin
        top_val = TMCAP_TOP_10BIT;
        fast_pwm = 1'b1;
      end
      4'h8, 4'hA: begin
        top_val = st_r.cap;
        dual_slope = 1'b1;
        cap_is_top = 1'b1;
      end
      4'h9, 4'hB: begin
        top_val = i_compare_a_top;
        dual_slope = 1'b1;
      end
      4'hC: begin
        top_val = st_r.cap;
        clear_at_top = 1'b1;
        cap_is_top = 1'b1;
      end
      4'hE: begin
        top_val = st_r.cap;
        fast_pwm = 1'b1;
        cap_is_top = 1'b1;
      end
      4'hF: begin
        top_val = i_compare_a_top;
        fast_pwm = 1'b1;
      end
      default: begin
        top_val = TMCAP_MAX;
      end
    endcase
  end

  // timer clock enable from prescaler taps or the synchronised external pin
  always_comb begin
    ext_edge_rise = st_r.ext_sync[1] & ~st_r.ext_prev;
    ext_edge_fall = ~st_r.ext_sync[1] & st_r.ext_prev;
    // RULE3 clock source pick
    // RULE7 stop when zero
    unique case (cs)
      TMCAP_CS_STOP: tick = 1'b0;
      TMCAP_CS_DIV1: tick = 1'b1;
      TMCAP_CS_DIV8: tick = (st_r.pre & TMCAP_PRE_DIV8) == TMCAP_PRE_DIV8;
      TMCAP_CS_DIV64: tick = (st_r.pre & TMCAP_PRE_DIV64) == TMCAP_PRE_DIV64;
      TMCAP_CS_DIV256: tick = (st_r.pre & TMCAP_PRE_DIV256) == TMCAP_PRE_DIV256;
      TMCAP_CS_DIV1024: tick = st_r.pre == TMCAP_PRE_DIV1024;
      TMCAP_CS_EXT_FALL: tick = ext_edge_fall;
      TMCAP_CS_EXT_RISE: tick = ext_edge_rise;
    endcase
  end

  // trigger selection, noise canceller and edge detector
  always_comb begin
    // comparator path exists only on the instance that has one
    // RULE11 trigger source
    // RULE17 comparator routing
    trig_raw = (HAS_COMPARATOR && st_r.cmp_sel) ? st_r.cmp_sync[1] : st_r.pin_sync[1];
    // output may only move when all four samples agree
    // RULE18 four equal samples
    nc_all_eq = (st_r.nc_sr == {TMCAP_NC_DEPTH{1'b1}}) || (st_r.nc_sr == {TMCAP_NC_DEPTH{1'b0}});
    nc_out = nc_all_eq ? st_r.nc_sr[TMCAP_NC_DEPTH-1] : st_r.nc_hold;
    // filtered path lags the raw one by the four sample stages
    // RULE19 four cycle delay
    // RULE20 canceller enable
    det_in = st_r.ctrl_b[TMCAP_B_NCANC_BIT] ? nc_out : trig_raw;
    // edge select: one takes rising, zero takes falling
    // RULE23 edge polarity
    // RULE21 detector gating
    // RULE12 edge match
    cap_event = ~cap_is_top && (det_in != st_r.det_prev) && (det_in == st_r.ctrl_b[TMCAP_B_EDGE_BIT]);
  end

  // register access, counter and capture next state
  always_comb begin
    st_nxt = st_r;
    wr_cnt_lo = i_bus.wr && (i_bus.addr == TMCAP_OFS_CNT_LO);
    wr_cap_lo = i_bus.wr && (i_bus.addr == TMCAP_OFS_CAP_LO) && cap_is_top;
    tov_set = 1'b0;

    // input synchronisers; only the second stage is read by logic
    st_nxt.ext_sync = {st_r.ext_sync[0], i_ext_clk_pin};
    st_nxt.ext_prev = st_r.ext_sync[1];
    st_nxt.pin_sync = {st_r.pin_sync[0], i_capture_input_pin};
    st_nxt.cmp_sync = {st_r.cmp_sync[0], i_comparator_output};
    // canceller samples every system clock, independent of prescaler
    // RULE20 system clock sampling
    st_nxt.nc_sr = {st_r.nc_sr[TMCAP_NC_DEPTH-2:0], trig_raw};
    st_nxt.nc_hold = nc_out;
    st_nxt.det_prev = det_in;
    st_nxt.pre = st_r.pre + 1'b1;

    // counting sequence, only on an active timer clock
    if (tick) begin
      // RULE4 step or clear
      if (dual_slope) begin
        if (!st_r.down) begin
          if (st_r.cnt >= top_val) begin
            st_nxt.down = 1'b1;
            st_nxt.cnt = st_r.cnt - 1'b1;
          end else begin
            st_nxt.cnt = st_r.cnt + 1'b1;
          end
        end else begin
          if (st_r.cnt == TMCAP_BOTTOM) begin
            st_nxt.down = 1'b0;
            st_nxt.cnt = st_r.cnt + 1'b1;
          end else begin
            st_nxt.cnt = st_r.cnt - 1'b1;
          end
        end
        // dual slope modes overflow at the bottom turn
        // RULE10 overflow point
        tov_set = st_r.down && (st_r.cnt == TMCAP_BOTTOM + 16'h0001);
      end else begin
        st_nxt.down = 1'b0;
        if ((fast_pwm || clear_at_top) && st_r.cnt == top_val) begin
          st_nxt.cnt = TMCAP_BOTTOM;
        end else begin
          st_nxt.cnt = st_r.cnt + 1'b1;
        end
        // fast modes overflow at TOP, normal and clear modes at MAX
        // RULE10 overflow point
        tov_set = fast_pwm ? (st_r.cnt == top_val) : (st_r.cnt == TMCAP_MAX);
      end
    end

    // software write wins; the pending step and its overflow are dropped
    // RULE8 write priority
    // RULE6 latch into upper byte
    if (wr_cnt_lo) begin
      st_nxt.cnt = {st_r.temp, i_bus.wdata};
      tov_set = 1'b0;
    end

    // shared latch loads from upper-byte writes and low-byte reads only;
    // low-byte writes leave it alone so it can be reused
    // RULE1 shared latch
    // RULE2 latch retained
    if (i_bus.wr && (i_bus.addr == TMCAP_OFS_CNT_HI || i_bus.addr == TMCAP_OFS_CAP_HI)) begin
      st_nxt.temp = i_bus.wdata;
    end
    // RULE6 low read loads latch
    // RULE15 capture low first
    if (i_bus.rd && i_bus.addr == TMCAP_OFS_CNT_LO) begin
      st_nxt.temp = st_r.cnt[15:8];
    end
    if (i_bus.rd && i_bus.addr == TMCAP_OFS_CAP_LO) begin
      st_nxt.temp = st_r.cap[15:8];
    end

    // control bytes; reserved bits are not stored and read as zero
    if (i_bus.wr && i_bus.addr == TMCAP_OFS_CTRL_A) begin
      st_nxt.ctrl_a = {6'h00, i_bus.wdata[TMCAP_A_WGM_LSB +: 2]};
    end
    if (i_bus.wr && i_bus.addr == TMCAP_OFS_CTRL_B) begin
      st_nxt.ctrl_b = i_bus.wdata & 8'hDF;
    end
    if (i_bus.wr && i_bus.addr == TMCAP_OFS_CMP_CS) begin
      // switching may fire a capture; software clears the flag after
      // RULE17 comparator select
      st_nxt.cmp_sel = HAS_COMPARATOR & i_bus.wdata[TMCAP_C_SEL_BIT];
    end

    // capture register writable only while it defines TOP
    // RULE16 write gating
    if (wr_cap_lo) begin
      st_nxt.cap = {st_r.temp, i_bus.wdata};
    end
    // every capture overwrites, read or not; pin driven by software counts too
    // RULE12 copy counter
    // RULE22 overwrite on capture
    if (cap_event) begin
      st_nxt.cap = st_r.cnt;
    end

    // flags: acknowledge or write-one clears, a set in the same cycle wins
    // RULE14 flag clear
    if (i_capture_irq_ack || (i_bus.wr && i_bus.addr == TMCAP_OFS_FLAGS && i_bus.wdata[TMCAP_F_CAP_BIT])) begin
      st_nxt.capf = 1'b0;
    end
    if (i_overflow_irq_ack || (i_bus.wr && i_bus.addr == TMCAP_OFS_FLAGS && i_bus.wdata[TMCAP_F_OVF_BIT])) begin
      st_nxt.ovf = 1'b0;
    end
    // RULE13 flag with capture
    if (cap_event) begin
      st_nxt.capf = 1'b1;
    end
    // RULE10 overflow flag set
    if (tov_set) begin
      st_nxt.ovf = 1'b1;
    end

    // extremes follow the value the counter is about to hold
    // RULE5 top and bottom
    st_nxt.top = st_nxt.cnt == top_val;
    st_nxt.bottom = st_nxt.cnt == TMCAP_BOTTOM;

    // read data stands one cycle after the strobe; upper bytes return the latch
    st_nxt.rdata = TMCAP_RST_BYTE;
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        TMCAP_OFS_CTRL_A: st_nxt.rdata = st_r.ctrl_a;
        TMCAP_OFS_CTRL_B: st_nxt.rdata = st_r.ctrl_b;
        TMCAP_OFS_CNT_LO: st_nxt.rdata = st_r.cnt[7:0];
        // RULE6 upper reads latch
        TMCAP_OFS_CNT_HI: st_nxt.rdata = st_r.temp;
        TMCAP_OFS_CAP_LO: st_nxt.rdata = st_r.cap[7:0];
        // RULE15 upper reads latch
        TMCAP_OFS_CAP_HI: st_nxt.rdata = st_r.temp;
        TMCAP_OFS_FLAGS: st_nxt.rdata = {6'h00, st_r.capf, st_r.ovf};
        TMCAP_OFS_CMP_CS: st_nxt.rdata = {5'h00, st_r.cmp_sel, 2'h0};
        default: st_nxt.rdata = TMCAP_RST_BYTE;
      endcase
    end
  end

  // single state register; reset loads constants only
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= '0;
      st_r.cnt <= TMCAP_RST_WORD;
      st_r.cap <= TMCAP_RST_WORD;
      st_r.bottom <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign o_rdata = st_r.rdata;
  assign o_overflow_flag = st_r.ovf;
  assign o_capture_flag = st_r.capf;
  // one driver for the whole struct; field order is value, mode, top, bottom, down
  assign o_counter = {st_r.cnt, wgm, st_r.top, st_r.bottom, st_r.down};
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench for the timer counter and capture block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tmcap_pkg::*;
  logic i_sys_clk, i_arst_n, cap_pin, cmp_out, ext_pin, ovf_ack, cap_ack, ovf_flag, cap_flag;
  logic [7:0] rdata, q;
  logic [15:0] v, c, h;
  tmcap_bus_s bus;
  tmcap_cnt_s cnt;
  int miscompares, checked, n, m;
  int dv[5] = '{1, 8, 64, 256, 1024};
  tmcap_cpu_model u_cpu (.i_sys_clk(i_sys_clk), .i_rdata(rdata), .o_bus(bus));
  tmcap_timer16 u_dut (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_bus(bus), .o_rdata(rdata),
    .i_capture_input_pin(cap_pin), .i_comparator_output(cmp_out), .i_ext_clk_pin(ext_pin),
    .i_compare_a_top(16'h8000), .i_overflow_irq_ack(ovf_ack), .i_capture_irq_ack(cap_ack),
    .o_overflow_flag(ovf_flag), .o_capture_flag(cap_flag), .o_counter(cnt));
  task automatic complete_run();
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    u_cpu.acc(1'b1, a, d, q);
  endtask
  task automatic rd8(input logic [3:0] a, input logic [7:0] e);
    u_cpu.acc(1'b0, a, 8'h00, q);
    check(16'(q), 16'(e));
  endtask
  task automatic waitc(input int k);
    repeat (k) @(posedge i_sys_clk);
  endtask
  // control B image: canceller, edge, mode high bits, clock select
  function automatic logic [7:0] cb(logic nc, logic ed, logic [1:0] mh, logic [2:0] cs);
    return {nc, ed, 1'b0, mh, cs};
  endfunction
  // drive the trigger, count clock cycles until the flag shows
  task automatic edge_lat(input logic lvl, input int exp);
    cap_pin <= lvl;
    for (n = 1; n < 20; n++) begin
      @(negedge i_sys_clk);
      if (cap_flag === 1'b1) break;
    end
    @(posedge i_sys_clk);
    check(16'(n), 16'(exp));
  endtask
  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  // watchdog, well beyond the roughly 11k cycles of the sequence
  initial begin
    waitc(40000);
    miscompares++;
    complete_run();
  end
  initial begin
    {i_arst_n, cap_pin, cmp_out, ext_pin, ovf_ack, cap_ack} = 6'h00;
    miscompares = 0;
    checked = 0;
    void'($urandom(33));
    waitc(10);
    i_arst_n <= 1'b1;
    @(posedge i_sys_clk);
    // unmapped write ignored, then every index reads its reset value
    wr(4'(8 + $urandom_range(7)), 8'hFF);
    for (int a = 0; a < 16; a++) rd8(4'(a), 8'h00);
    // stopped counter still takes and returns a value
    v = 16'($urandom);
    u_cpu.w16(TMCAP_OFS_CNT_LO, v);
    waitc(20);
    u_cpu.r16(TMCAP_OFS_CNT_LO, h);
    check(h, v);
    // one upper write serves two lower writes, capture as TOP
    wr(TMCAP_OFS_CTRL_B, cb(1'b0, 1'b0, 2'h3, TMCAP_CS_STOP));
    v = 16'($urandom);
    c = 16'($urandom);
    wr(TMCAP_OFS_CNT_HI, v[15:8]);
    wr(TMCAP_OFS_CNT_LO, v[7:0]);
    wr(TMCAP_OFS_CAP_LO, c[7:0]);
    u_cpu.r16(TMCAP_OFS_CNT_LO, h);
    check(h, v);
    u_cpu.r16(TMCAP_OFS_CAP_LO, h);
    check(h, {v[15:8], c[7:0]});
    cap_pin <= 1'b1;
    waitc(12);
    cap_pin <= 1'b0;
    waitc(12);
    rd8(TMCAP_OFS_FLAGS, 8'h00);
    // capture register refuses writes in normal mode
    wr(TMCAP_OFS_CTRL_B, cb(1'b0, 1'b0, 2'h0, TMCAP_CS_STOP));
    u_cpu.w16(TMCAP_OFS_CAP_LO, ~c);
    u_cpu.r16(TMCAP_OFS_CAP_LO, h);
    check(h, {v[15:8], c[7:0]});
    // running counter: the write wins, then one step per clock
    wr(TMCAP_OFS_CTRL_B, cb(1'b0, 1'b0, 2'h0, TMCAP_CS_DIV1));
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? TMCAP_MAX : {1'b0, 15'($urandom)};
      u_cpu.w16(TMCAP_OFS_CNT_LO, v);
      u_cpu.r16(TMCAP_OFS_CNT_LO, h);
      check(h, v + 16'h0001);
    end
    wr(TMCAP_OFS_FLAGS, 8'h00);
    rd8(TMCAP_OFS_FLAGS, 8'h01);
    ovf_ack <= 1'b1;
    @(posedge i_sys_clk);
    ovf_ack <= 1'b0;
    rd8(TMCAP_OFS_FLAGS, 8'h00);
    // every prescaled source over a 2048-clock window
    for (int k = 0; k < 5; k++) begin
      wr(TMCAP_OFS_CTRL_B, cb(1'b0, 1'b0, 2'h0, TMCAP_CS_STOP));
      v = 16'($urandom);
      u_cpu.w16(TMCAP_OFS_CNT_LO, v);
      wr(TMCAP_OFS_CTRL_B, cb(1'b0, 1'b0, 2'h0, 3'(k + 1)));
      waitc(2046);
      wr(TMCAP_OFS_CTRL_B, cb(1'b0, 1'b0, 2'h0, TMCAP_CS_STOP));
      u_cpu.r16(TMCAP_OFS_CNT_LO, h);
      check(h, v + 16'(2048 / dv[k]));
    end
    // external pin, falling then rising; a trailing rise tells them apart
    for (int k = 6; k < 8; k++) begin
      ext_pin <= 1'b0;
      v = 16'($urandom);
      m = 1 + $urandom_range(5);
      u_cpu.w16(TMCAP_OFS_CNT_LO, v);
      wr(TMCAP_OFS_CTRL_B, cb(1'b0, 1'b0, 2'h0, 3'(k)));
      repeat (m) begin
        ext_pin <= 1'b1;
        waitc(4);
        ext_pin <= 1'b0;
        waitc(4);
      end
      ext_pin <= 1'b1;
      waitc(8);
      wr(TMCAP_OFS_CTRL_B, cb(1'b0, 1'b0, 2'h0, TMCAP_CS_STOP));
      u_cpu.r16(TMCAP_OFS_CNT_LO, h);
      check(h, v + 16'(m) + 16'(k == 7));
    end
    // capture: both edges, canceller off and on, glitch and clearing
    for (int i = 0; i < 4; i++) begin
      wr(TMCAP_OFS_CTRL_B, cb(i[1], i[0], 2'h0, TMCAP_CS_STOP));
      cap_pin <= ~i[0];
      waitc(12);
      // clear both flags; an earlier free run may have wrapped the counter
      wr(TMCAP_OFS_FLAGS, 8'h03);
      v = 16'($urandom);
      u_cpu.w16(TMCAP_OFS_CNT_LO, v);
      edge_lat(i[0], 4 + 4 * i[1]);
      u_cpu.r16(TMCAP_OFS_CAP_LO, h);
      check(h, v);
      wr(TMCAP_OFS_FLAGS, 8'h00);
      rd8(TMCAP_OFS_FLAGS, 8'h02);
      cap_ack <= 1'b1;
      @(posedge i_sys_clk);
      cap_ack <= 1'b0;
      rd8(TMCAP_OFS_FLAGS, 8'h00);
      cap_pin <= ~i[0];
      waitc(2);
      cap_pin <= i[0];
      waitc(12);
      rd8(TMCAP_OFS_FLAGS, i[1] ? 8'h00 : 8'h02);
      wr(TMCAP_OFS_FLAGS, 8'h02);
      cap_pin <= ~i[0];
      waitc(12);
      rd8(TMCAP_OFS_FLAGS, 8'h00);
    end
    // comparator only counts once routed
    wr(TMCAP_OFS_CTRL_B, cb(1'b0, 1'b1, 2'h0, TMCAP_CS_STOP));
    cmp_out <= 1'b1;
    waitc(12);
    rd8(TMCAP_OFS_FLAGS, 8'h00);
    cmp_out <= 1'b0;
    waitc(12);
    u_cpu.sel_cmp(1'b1);
    v = 16'($urandom);
    u_cpu.w16(TMCAP_OFS_CNT_LO, v);
    cmp_out <= 1'b1;
    waitc(12);
    rd8(TMCAP_OFS_FLAGS, 8'h02);
    u_cpu.r16(TMCAP_OFS_CAP_LO, h);
    check(h, v);
    u_cpu.sel_cmp(1'b0);
    // dual slope to 00FF and back down through bottom
    wr(TMCAP_OFS_CTRL_A, 8'h01);
    u_cpu.w16(TMCAP_OFS_CNT_LO, 16'h00F0);
    wr(TMCAP_OFS_CTRL_B, cb(1'b0, 1'b0, 2'h0, TMCAP_CS_DIV1));
    waitc(300);
    wr(TMCAP_OFS_CTRL_B, cb(1'b0, 1'b0, 2'h0, TMCAP_CS_STOP));
    rd8(TMCAP_OFS_FLAGS, 8'h01);
    u_cpu.r16(TMCAP_OFS_CNT_LO, h);
    check(16'(h <= TMCAP_TOP_8BIT), 16'h0001);
    check(16'(cnt.down), 16'h0000);
    complete_run();
  end
endmodule
`default_nettype wire

/* File: verif/tmcap_cpu_model.sv */
// processor model driving the byte-wide register port
`timescale 1ns/1ps
`default_nettype none
module tmcap_cpu_model (
  input wire logic i_sys_clk,
  input wire logic [7:0] i_rdata,
  output tmcap_pkg::tmcap_bus_s o_bus
);
  import tmcap_pkg::*;
  // idle before the first access
  initial o_bus = '0;
  // one access; lines scrambled afterwards so nobody leans on stale values
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    o_bus <= '{addr: a, wdata: d, wr: w, rd: ~w};
    @(posedge i_sys_clk);
    o_bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    @(negedge i_sys_clk);
    q = i_rdata;
    @(posedge i_sys_clk);
  endtask
  task automatic w16(input logic [3:0] lo, input logic [15:0] v);
    logic [7:0] q;
    acc(1'b1, lo + 4'h1, v[15:8], q);
    acc(1'b1, lo, v[7:0], q);
  endtask
  task automatic r16(input logic [3:0] lo, output logic [15:0] v);
    acc(1'b0, lo, 8'h00, v[7:0]);
    acc(1'b0, lo + 4'h1, 8'h00, v[15:8]);
  endtask
  task automatic sel_cmp(input logic b);
    logic [7:0] q;
    acc(1'b1, TMCAP_OFS_CMP_CS, 8'(b) << TMCAP_C_SEL_BIT, q);
    repeat (8) @(posedge i_sys_clk);
    acc(1'b1, TMCAP_OFS_FLAGS, 8'h02, q);
  endtask
endmodule
`default_nettype wire

/* File: verif/tmcap_timer16_monitor.sv */
// port checker for the timer counter and capture block
`timescale 1ns/1ps
`default_nettype none
module tmcap_timer16_monitor (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire tmcap_pkg::tmcap_bus_s i_bus,
  input wire logic [7:0] o_rdata,
  input wire logic i_capture_input_pin,
  input wire logic i_comparator_output,
  input wire logic i_overflow_irq_ack,
  input wire logic i_capture_irq_ack,
  input wire logic o_overflow_flag,
  input wire logic o_capture_flag,
  input wire tmcap_pkg::tmcap_cnt_s o_counter
);
  import tmcap_pkg::*;
  logic [15:0] cnt1_r, cnt2_r, cnt3_r;
  logic [3:0] since_r;
  logic pin_r, cmp_r, wr_lo, wr_hi, rd_lo, rd_hi, clr_ovf, clr_cap, stir;
  // decoded strobes; control writes may legally provoke a capture, so they count as stir
  assign wr_lo = i_bus.wr && i_bus.addr == TMCAP_OFS_CNT_LO;
  assign wr_hi = i_bus.wr && i_bus.addr == TMCAP_OFS_CNT_HI;
  assign rd_lo = i_bus.rd && i_bus.addr == TMCAP_OFS_CNT_LO;
  assign rd_hi = i_bus.rd && i_bus.addr == TMCAP_OFS_CNT_HI;
  assign clr_ovf = i_bus.wr && i_bus.addr == TMCAP_OFS_FLAGS && i_bus.wdata[TMCAP_F_OVF_BIT];
  assign clr_cap = i_bus.wr && i_bus.addr == TMCAP_OFS_FLAGS && i_bus.wdata[TMCAP_F_CAP_BIT];
  assign stir = i_capture_input_pin != pin_r || i_comparator_output != cmp_r ||
    (i_bus.wr && (i_bus.addr <= TMCAP_OFS_CTRL_B || i_bus.addr == TMCAP_OFS_CMP_CS));
  // counter history and clocks since the last trigger activity, saturating
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt1_r <= 16'h0000;
      cnt2_r <= 16'h0000;
      cnt3_r <= 16'h0000;
      since_r <= 4'h0;
      pin_r <= 1'b0;
      cmp_r <= 1'b0;
    end else begin
      cnt1_r <= o_counter.value;
      cnt2_r <= cnt1_r;
      cnt3_r <= cnt2_r;
      since_r <= stir ? 4'h0 : since_r + {3'h0, since_r != 4'hF};
      pin_r <= i_capture_input_pin;
      cmp_r <= i_comparator_output;
    end
  end
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_arst_n);
  sequence cnt_wr_s;
    wr_hi ##2 wr_lo;
  endsequence
  sequence cnt_rd_s;
    rd_lo ##2 rd_hi;
  endsequence
  rdata_idle_a: assert property (!i_bus.rd |=> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  low_read_a: assert property (rd_lo |=> o_rdata == cnt1_r[7:0])
    else $error("counter low byte read wrong");
  latch_read_a: assert property (cnt_rd_s |=> o_rdata == cnt3_r[15:8])
    else $error("upper byte not taken from latch");
  cnt_write_a: assert property (cnt_wr_s |=> o_counter.value == {$past(i_bus.wdata, 3), $past(i_bus.wdata)})
    else $error("counter write lost");
  cnt_step_a: assert property (!wr_lo |=>
    (o_counter.value - cnt1_r) inside {16'h0000, 16'h0001, 16'hFFFF} || o_counter.value == 16'h0000)
    else $error("counter moved by more than one");
  down_step_a: assert property ($rose(o_counter.down) && !$past(wr_lo) |-> o_counter.value == cnt1_r - 16'h0001)
    else $error("turn to down count did not step down");
  bottom_flag_a: assert property (o_counter.bottom == (o_counter.value == TMCAP_BOTTOM))
    else $error("bottom indication wrong");
  top_dual_a: assert property ((o_counter.mode == 4'h1 && $past(o_counter.mode) == 4'h1) |->
    o_counter.top == (o_counter.value == TMCAP_TOP_8BIT))
    else $error("top indication wrong");
  ovf_bottom_a: assert property ($rose(o_overflow_flag) |-> o_counter.bottom)
    else $error("overflow away from bottom");
  ovf_clear_a: assert property ($fell(o_overflow_flag) |-> $past(i_overflow_irq_ack) || $past(clr_ovf))
    else $error("overflow flag cleared without cause");
  cap_clear_a: assert property ($fell(o_capture_flag) |-> $past(i_capture_irq_ack) || $past(clr_cap))
    else $error("capture flag cleared without cause");
  cap_cause_a: assert property ($rose(o_capture_flag) |-> since_r <= 4'h7)
    else $error("capture flag without trigger");
endmodule
bind tmcap_timer16 tmcap_timer16_monitor u_mon (
  .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_bus(i_bus), .o_rdata(o_rdata),
  .i_capture_input_pin(i_capture_input_pin), .i_comparator_output(i_comparator_output),
  .i_overflow_irq_ack(i_overflow_irq_ack), .i_capture_irq_ack(i_capture_irq_ack),
  .o_overflow_flag(o_overflow_flag), .o_capture_flag(o_capture_flag), .o_counter(o_counter)
);
`default_nettype wire
